// ### shared/receive_info_pkg.sv
// package: constants of the receive information register bank
// assumes: shared by the bank and its one-second timer
package receive_info_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 8;
  localparam logic [7:0]  EVENT_FLAGS_OFF = 8'h08;
  localparam logic [7:0]  LEVEL_LOOP_OFF  = 8'h09;
  localparam logic [7:0]  RESET_VALUE     = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned ZERO_RUN_POS    = 7;
  localparam int unsigned SIXTEEN_POS     = 6;
  localparam int unsigned CODE_WORD_POS   = 5;
  localparam int unsigned CL_CLEARED_POS  = 4;
  localparam int unsigned AO_CLEARED_POS  = 3;
  localparam int unsigned JB_TRIP_POS     = 2;
  localparam int unsigned LEVEL_LSB_POS   = 4;
  localparam int unsigned LOOPBACK_POS    = 1;
  localparam int unsigned SECOND_POS      = 0;
  localparam int unsigned NUM_EVENTS      = 6;

  // ----------------------------------------------------------------
  // line thresholds in bits, and the B8ZS code word mark and violation patterns
  // ----------------------------------------------------------------
  localparam logic [4:0] ZERO_RUN_E1      = 5'h04;
  localparam logic [4:0] ZERO_RUN_T1      = 5'h08;
  localparam logic [4:0] SIXTEEN_ZEROS    = 5'h10;
  localparam logic [7:0] CL_WINDOW_E1     = 8'hff;
  localparam logic [7:0] CL_WINDOW_T1     = 8'h70;
  localparam logic [5:0] CL_ONES_E1       = 6'h20;
  localparam logic [5:0] CL_ONES_T1       = 6'h0e;
  localparam logic [7:0] JB_MARGIN        = 8'h04;
  localparam logic [7:0] JB_DEPTH_SHORT   = 8'h20;
  localparam logic [7:0] JB_DEPTH_LONG    = 8'h80;
  localparam logic [7:0] B8ZS_MARKS       = 8'h1b;
  localparam logic [7:0] B8ZS_VIOLATIONS  = 8'h12;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned E1_BITS_PER_SEC = 2048000;
  localparam int unsigned T1_BITS_PER_SEC = 1544000;
  localparam int unsigned SEC_CNT_W       = 21;
  localparam logic [2:0]  LOOP_SECONDS    = 3'h5;

  typedef enum logic {
    LOOP_IDLE,
    LOOP_ACTIVE
  } loop_state_t;

endpackage : receive_info_pkg

// ### rtl/one_second_timer.sv
// file: one-second tick from the recovered receive bit rate
// assumes: rx_bit_en pulses once per received bit, synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none

module one_second_timer #(
  parameter int unsigned E1_COUNT = receive_info_pkg::E1_BITS_PER_SEC,
  parameter int unsigned T1_COUNT = receive_info_pkg::T1_BITS_PER_SEC
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic rx_bit_en,
  input  wire logic t1_select,
  output logic      sec_tick
);
  import receive_info_pkg::*;

  // ----------------------------------------------------------------
  // bit counter
  // ----------------------------------------------------------------
  logic [SEC_CNT_W-1:0] cnt_reg;
  logic [SEC_CNT_W-1:0] cnt_next;
  logic [SEC_CNT_W-1:0] last_cnt;
  logic                 tick_reg;
  logic                 tick_next;

  always_comb begin
    last_cnt  = t1_select ? SEC_CNT_W'(T1_COUNT - 1) : SEC_CNT_W'(E1_COUNT - 1);
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (rx_bit_en) begin
      if (cnt_reg >= last_cnt) begin
        cnt_next  = '0;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign sec_tick = tick_reg;

endmodule // one_second_timer

`default_nettype wire

// ### rtl/receive_info_flags.sv
// file: receive information register bank with its event detectors
// assumes: received bits arrive as bipolar marks with a bit enable;
//          alarms, level code and loop code detections come from
//          neighbouring blocks as levels synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none

module receive_info_flags #(
  parameter int unsigned E1_COUNT = receive_info_pkg::E1_BITS_PER_SEC,
  parameter int unsigned T1_COUNT = receive_info_pkg::T1_BITS_PER_SEC
) (
  input  wire logic                                ref_clk,
  input  wire logic                                rst_n,
  input  wire logic [receive_info_pkg::ADDR_W-1:0] addr,
  input  wire logic                                rd_strobe,
  output logic      [receive_info_pkg::DATA_W-1:0] rd_data,
  input  wire logic                                t1_select,
  input  wire logic                                rx_bit_en,
  input  wire logic                                rx_pos,
  input  wire logic                                rx_neg,
  input  wire logic                                carrier_loss_alarm,
  input  wire logic                                unframed_all_ones_alarm,
  input  wire logic [7:0]                          jitter_fifo_fill,
  input  wire logic                                jitter_fifo_long,
  input  wire logic [3:0]                          rx_level_code,
  input  wire logic                                auto_loopback_enable,
  input  wire logic                                loop_up_seen,
  input  wire logic                                loop_down_seen,
  output logic                                     remote_loopback_active
);
  import receive_info_pkg::*;

  // ----------------------------------------------------------------
  // received symbol history
  // ----------------------------------------------------------------
  logic       mark;
  logic       viol;
  logic       last_pol_reg;
  logic       last_pol_next;
  logic [7:0] mark_hist_reg;
  logic [7:0] mark_hist_next;
  logic [7:0] viol_hist_reg;
  logic [7:0] viol_hist_next;
  logic [4:0] zero_cnt_reg;
  logic [4:0] zero_cnt_next;
  logic       ao_prev_reg;
  logic       ao_prev_next;

  always_comb begin
    mark           = rx_pos | rx_neg;
    viol           = mark && (rx_pos == last_pol_reg) && mark_hist_reg != 8'h00;
    last_pol_next  = last_pol_reg;
    mark_hist_next = mark_hist_reg;
    viol_hist_next = viol_hist_reg;
    zero_cnt_next  = zero_cnt_reg;
    ao_prev_next   = unframed_all_ones_alarm;
    if (rx_bit_en) begin
      if (mark) begin
        last_pol_next = rx_pos;
      end
      mark_hist_next = {mark_hist_reg[6:0], mark};
      viol_hist_next = {viol_hist_reg[6:0], viol};
      if (mark) begin
        zero_cnt_next = 5'h00;
      end else if (zero_cnt_reg < SIXTEEN_ZEROS) begin
        zero_cnt_next = zero_cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      last_pol_reg  <= 1'b0;
      mark_hist_reg <= 8'h00;
      viol_hist_reg <= 8'h00;
      zero_cnt_reg  <= 5'h00;
      ao_prev_reg   <= 1'b0;
    end else begin
      last_pol_reg  <= last_pol_next;
      mark_hist_reg <= mark_hist_next;
      viol_hist_reg <= viol_hist_next;
      zero_cnt_reg  <= zero_cnt_next;
      ao_prev_reg   <= ao_prev_next;
    end
  end

  // ----------------------------------------------------------------
  // carrier loss clear window
  // ----------------------------------------------------------------
  logic       cl_run_reg;
  logic       cl_run_next;
  logic [7:0] cl_bits_reg;
  logic [7:0] cl_bits_next;
  logic [5:0] cl_ones_reg;
  logic [5:0] cl_ones_next;
  logic       cl_met;
  logic [7:0] cl_window;
  logic [5:0] cl_need;

  always_comb begin
    cl_window    = t1_select ? CL_WINDOW_T1 : CL_WINDOW_E1;
    cl_need      = t1_select ? CL_ONES_T1 : CL_ONES_E1;
    cl_run_next  = cl_run_reg;
    cl_bits_next = cl_bits_reg;
    cl_ones_next = cl_ones_reg;
    cl_met       = 1'b0;
    if (!carrier_loss_alarm) begin
      cl_run_next = 1'b0;
    end else if (rx_bit_en) begin
      if (!cl_run_reg) begin
        if (mark) begin
          cl_run_next  = 1'b1;
          cl_bits_next = 8'h01;
          cl_ones_next = 6'h01;
        end
      end else begin
        cl_bits_next = cl_bits_reg + 8'h01;
        cl_ones_next = cl_ones_reg + {5'h00, mark};
        if (cl_ones_next >= cl_need) begin
          cl_met      = 1'b1;
          cl_run_next = 1'b0;
        end else if (cl_bits_next >= cl_window) begin
          cl_run_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cl_run_reg  <= 1'b0;
      cl_bits_reg <= 8'h00;
      cl_ones_reg <= 6'h00;
    end else begin
      cl_run_reg  <= cl_run_next;
      cl_bits_reg <= cl_bits_next;
      cl_ones_reg <= cl_ones_next;
    end
  end

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  logic                  sec_tick;
  logic [NUM_EVENTS-1:0] ev_set;
  logic [7:0]            jb_limit;
  logic                  hdb3_word;
  logic                  b8zs_word;

  one_second_timer #(
    .E1_COUNT (E1_COUNT),
    .T1_COUNT (T1_COUNT)
  ) u_sec (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .rx_bit_en (rx_bit_en),
    .t1_select (t1_select),
    .sec_tick  (sec_tick)
  );

  always_comb begin
    jb_limit  = jitter_fifo_long ? JB_DEPTH_LONG : JB_DEPTH_SHORT;
    hdb3_word = rx_bit_en && viol && mark_hist_reg[1:0] == 2'b00;
    b8zs_word = rx_bit_en && {mark_hist_reg[6:0], mark} == B8ZS_MARKS
                && {viol_hist_reg[6:0], viol} == B8ZS_VIOLATIONS;
    ev_set    = '0;
    ev_set[ZERO_RUN_POS-2]   = rx_bit_en && !mark
                               && zero_cnt_next >= (t1_select ? ZERO_RUN_T1 : ZERO_RUN_E1);
    ev_set[SIXTEEN_POS-2]    = rx_bit_en && !mark && zero_cnt_next >= SIXTEEN_ZEROS;
    ev_set[CODE_WORD_POS-2]  = t1_select ? b8zs_word : hdb3_word;
    ev_set[CL_CLEARED_POS-2] = cl_met;
    ev_set[AO_CLEARED_POS-2] = ao_prev_reg && !unframed_all_ones_alarm;
    ev_set[JB_TRIP_POS-2]    = jitter_fifo_fill >= (jb_limit - JB_MARGIN)
                               || jitter_fifo_fill <= JB_MARGIN;
  end

  // ----------------------------------------------------------------
  // latched flags, read clears
  // ----------------------------------------------------------------
  logic                  rd_events;
  logic                  rd_level;
  logic [NUM_EVENTS-1:0] ev_reg;
  logic                  sec_reg;
  logic                  sec_next;

  assign rd_events = rd_strobe && addr == EVENT_FLAGS_OFF;
  assign rd_level  = rd_strobe && addr == LEVEL_LOOP_OFF;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_flag
      logic ev_next;
      always_comb begin
        ev_next = (ev_reg[gi] && !rd_events) || ev_set[gi];
      end
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          ev_reg[gi] <= 1'b0;
        end else begin
          ev_reg[gi] <= ev_next;
        end
      end
    end
  endgenerate

  always_comb begin
    sec_next = (sec_reg && !rd_level) || sec_tick;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sec_reg <= 1'b0;
    end else begin
      sec_reg <= sec_next;
    end
  end

  // ----------------------------------------------------------------
  // automatic remote loopback
  // ----------------------------------------------------------------
  loop_state_t loop_reg;
  loop_state_t loop_next;
  logic [2:0]  loop_cnt_reg;
  logic [2:0]  loop_cnt_next;
  logic        code_seen;

  always_comb begin
    loop_next     = loop_reg;
    loop_cnt_next = loop_cnt_reg;
    code_seen     = (loop_reg == LOOP_IDLE) ? loop_up_seen : loop_down_seen;
    if (!auto_loopback_enable) begin
      loop_next     = LOOP_IDLE;
      loop_cnt_next = 3'h0;
    end else if (!code_seen) begin
      loop_cnt_next = 3'h0;
    end else if (sec_tick) begin
      if (loop_cnt_reg + 3'h1 >= LOOP_SECONDS) begin
        loop_cnt_next = 3'h0;
        case (loop_reg)
          LOOP_IDLE:   loop_next = LOOP_ACTIVE;
          LOOP_ACTIVE: loop_next = LOOP_IDLE;
          default:     loop_next = LOOP_IDLE;
        endcase
      end else begin
        loop_cnt_next = loop_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      loop_reg     <= LOOP_IDLE;
      loop_cnt_reg <= 3'h0;
    end else begin
      loop_reg     <= loop_next;
      loop_cnt_reg <= loop_cnt_next;
    end
  end

  assign remote_loopback_active = loop_reg == LOOP_ACTIVE;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;

  always_comb begin
    rd_data_next = rd_data_reg;
    if (rd_events) begin
      rd_data_next = {ev_reg, 2'b00};
    end else if (rd_level) begin
      rd_data_next = RESET_VALUE;
      rd_data_next[LEVEL_LSB_POS +: 4] = rx_level_code;
      rd_data_next[LOOPBACK_POS]       = remote_loopback_active;
      rd_data_next[SECOND_POS]         = sec_reg;
    end else if (rd_strobe) begin
      rd_data_next = RESET_VALUE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data_reg <= RESET_VALUE;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;

endmodule // receive_info_flags

`default_nettype wire

// ### bench/receive_info_flags_asserts.sv
// checker: port assertions for the receive information bank
// assumes: bound to every receive_info_flags instance
`timescale 1ns/100ps
`default_nettype none

module receive_info_flags_asserts (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [7:0] addr,
  input wire logic       rd_strobe,
  input wire logic [7:0] rd_data,
  input wire logic [3:0] rx_level_code,
  input wire logic       auto_loopback_enable,
  input wire logic       loop_up_seen,
  input wire logic       loop_down_seen,
  input wire logic       remote_loopback_active
);
  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  logic rd_ev;
  logic rd_lv;
  assign rd_ev = rd_strobe && addr == 8'h08;
  assign rd_lv = rd_strobe && addr == 8'h09;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_n |=> rd_data == 8'h00 && !remote_loopback_active) else $error("reset left outputs set");
  hold_data_a: assert property (!rd_strobe |=> $stable(rd_data)) else $error("data moved");
  spare_bits_a: assert property (rd_ev |=> rd_data[1:0] == 2'b00)
    else $error("spare event bits set");
  level_live_a: assert property (rd_lv |=> rd_data[7:4] == $past(rx_level_code)
    && rd_data[3:2] == 2'b00) else $error("level field wrong");
  loop_read_a: assert property (rd_lv |=> rd_data[1] == $past(remote_loopback_active))
    else $error("loopback bit wrong");
  loop_off_a: assert property (!auto_loopback_enable |=> !remote_loopback_active)
    else $error("loopback not forced low");
  loop_rise_a: assert property ($rose(remote_loopback_active) |->
    $past(loop_up_seen) && $past(auto_loopback_enable)) else $error("loopback rose early");
  loop_fall_a: assert property ($fell(remote_loopback_active) && $past(rst_n) |->
    $past(loop_down_seen) || !$past(auto_loopback_enable)) else $error("loopback fell early");
  sixteen_zero_a: assert property (rd_ev ##1 rd_data[6] |-> rd_data[7])
    else $error("sixteen without zero run");
endmodule // receive_info_flags_asserts

bind receive_info_flags receive_info_flags_asserts receive_info_flags_asserts_inst (
  .ref_clk, .rst_n, .addr, .rd_strobe, .rd_data, .rx_level_code, .auto_loopback_enable,
  .loop_up_seen, .loop_down_seen, .remote_loopback_active);

`default_nettype wire

// ### bench/receive_info_flags_tb.sv
// testbench: receive information bank, table rows then line cases
// assumes: second counts shortened to 16 and 12 bits
`timescale 1ns/100ps
`default_nettype none

module receive_info_flags_tb;
  import receive_info_pkg::*;
  localparam logic [1:0] P = 2'b10, N = 2'b01, Z = 2'b00;
  logic       ref_clk, rst_n, rd_strobe, t1_select, rx_bit_en, rx_pos, rx_neg;
  logic       carrier_loss_alarm, unframed_all_ones_alarm, jitter_fifo_long;
  logic       auto_loopback_enable, loop_up_seen, loop_down_seen, remote_loopback_active;
  logic [7:0] addr, rd_data, jitter_fifo_fill;
  logic [3:0] rx_level_code;
  int         n_fail = 0, n_tests = 0, cyc = 0, i;
  typedef struct packed {logic [7:0] a; logic [3:0] lv; logic [7:0] exp;} row_t;
  row_t       rows [5] = '{'{8'h09, 4'h6, 8'h60}, '{8'h08, 4'hf, 8'h00},
                           '{8'h00, 4'hf, 8'h00}, '{8'h0a, 4'hf, 8'h00}, '{8'hff, 4'h5, 8'h00}};
  logic [7:0] jt [6] = '{8'h1b, 8'h1c, 8'h05, 8'h04, 8'h7b, 8'h7c};

  receive_info_flags #(.E1_COUNT(16), .T1_COUNT(12)) receive_info_flags_inst (
    .ref_clk, .rst_n, .addr, .rd_strobe, .rd_data, .t1_select, .rx_bit_en, .rx_pos, .rx_neg,
    .carrier_loss_alarm, .unframed_all_ones_alarm, .jitter_fifo_fill, .jitter_fifo_long,
    .rx_level_code, .auto_loopback_enable, .loop_up_seen, .loop_down_seen,
    .remote_loopback_active);

  // ----------------------------------------------------------------
  // clock, timeout, tasks
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compares %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic step(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic send(logic [1:0] s);
    {rx_bit_en, rx_pos, rx_neg} = {1'b1, s};
    step();
  endtask
  task automatic zeros(int n, logic [1:0] last);
    repeat (n) send(Z);
    send(last);
  endtask
  task automatic ones(int n);
    for (int k = 0; k < n; k++) send(k[0] ? N : P);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp, logic [7:0] m = 8'hff);
    rx_bit_en = 1'b0;
    addr = a;
    rd_strobe = 1'b1;
    step();
    rd_strobe = 1'b0;
    chk(rd_data & m, exp);
    step();
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, addr, rd_strobe, t1_select, rx_bit_en, rx_pos, rx_neg} = '0;
    {carrier_loss_alarm, unframed_all_ones_alarm, jitter_fifo_long, rx_level_code} = '0;
    {auto_loopback_enable, loop_up_seen, loop_down_seen} = '0;
    jitter_fifo_fill = 8'h10;
    step(16);
    rst_n = 1'b1;
    chk(rd_data, 8'h00);
    for (i = 0; i < 5; i++) begin
      rx_level_code = rows[i].lv;
      rd(rows[i].a, rows[i].exp);
    end
    for (i = 0; i < 16; i++) begin
      rx_level_code = i[3:0];
      rd(8'h09, {i[3:0], 4'h0});
    end
    send(P);
    zeros(3, N);
    rd(8'h08, 8'h00);
    zeros(4, P);
    rd(8'h08, 8'h80);
    rd(8'h08, 8'h00);
    zeros(15, N);
    rd(8'h08, 8'h80);
    zeros(16, P);
    rd(8'h08, 8'hc0);
    t1_select = 1'b1;
    zeros(7, N);
    rd(8'h08, 8'h00);
    zeros(8, P);
    rd(8'h08, 8'h80);
    zeros(3, P);
    send(N);
    send(Z);
    send(N);
    send(P);
    rd(8'h08, 8'h20);
    t1_select = 1'b0;
    zeros(2, P);
    rd(8'h08, 8'h20);
    for (i = 0; i < 2; i++) begin
      t1_select = i[0];
      carrier_loss_alarm = 1'b1;
      ones(i ? 13 : 31);
      rd(8'h08, 8'h00);
      ones(1);
      rd(8'h08, 8'h10);
      carrier_loss_alarm = 1'b0;
    end
    unframed_all_ones_alarm = 1'b1;
    step(2);
    rd(8'h08, 8'h00);
    unframed_all_ones_alarm = 1'b0;
    step(2);
    rd(8'h08, 8'h08);
    for (i = 0; i < 6; i++) begin
      jitter_fifo_long = i > 3;
      jitter_fifo_fill = jt[i];
      step();
      jitter_fifo_fill = 8'h10;
      rd(8'h08, i[0] ? 8'h04 : 8'h00);
    end
    t1_select = 1'b0;
    repeat (3) send(Z);
    addr = 8'h08;
    rd_strobe = 1'b1;
    send(Z);
    rd_strobe = 1'b0;
    send(N);
    rd(8'h08, 8'h80);
    rd(8'h09, 8'h00, 8'h00);
    ones(17);
    rx_bit_en = 1'b0;
    step();
    rd(8'h09, 8'h01, 8'h01);
    rd(8'h09, 8'h00, 8'h01);
    auto_loopback_enable = 1'b1;
    for (i = 0; i < 5; i++) begin
      {loop_up_seen, loop_down_seen} = (i == 2 || i == 3) ? 2'b01 : 2'b10;
      ones(48);
      rd(8'h09, (i == 1 || i == 2) ? 8'h02 : 8'h00, 8'h02);
    end
    ones(48);
    chk({7'h00, remote_loopback_active}, 8'h01);
    auto_loopback_enable = 1'b0;
    step(2);
    chk({7'h00, remote_loopback_active}, 8'h00);
    auto_loopback_enable = 1'b1;
    ones(96);
    chk({7'h00, remote_loopback_active}, 8'h01);
    rst_n = 1'b0;
    step(2);
    chk({rd_data[7:1], remote_loopback_active}, 8'h00);
    print_verdict();
  end
endmodule // receive_info_flags_tb

`default_nettype wire
